// >>> verilog/door_lamp_map.vh
`ifndef DOOR_LAMP_MAP_VH
`define DOOR_LAMP_MAP_VH

// -----------------------------------------------------------------
// timebase
// -----------------------------------------------------------------
`define CLK_KHZ          32'd100000

// -----------------------------------------------------------------
// times in milliseconds
// -----------------------------------------------------------------
`define POS_DEB_MS       32'd500
`define PB_DEB_MS        32'd26
`define LAMP_TEST_MS     32'd500
`define CTRL_PULSE_MS    32'd500
`define ALT_TIME_MS      32'd30000
`define FLASH_HALF_MS    32'd250

// -----------------------------------------------------------------
// derived cycle counts (all fit an unsigned 32-bit word)
// -----------------------------------------------------------------
`define POS_DEB_CYC      (`POS_DEB_MS * `CLK_KHZ)
`define PB_DEB_CYC       (`PB_DEB_MS * `CLK_KHZ)
`define LAMP_TEST_CYC    (`LAMP_TEST_MS * `CLK_KHZ)
`define CTRL_PULSE_CYC   (`CTRL_PULSE_MS * `CLK_KHZ)
`define ALT_TIME_CYC     (`ALT_TIME_MS * `CLK_KHZ)
`define FLASH_HALF_CYC   (`FLASH_HALF_MS * `CLK_KHZ)

// -----------------------------------------------------------------
// input bit positions inside the sampled input vector
// -----------------------------------------------------------------
`define IN_SHUT          0
`define IN_FULL          1
`define IN_BUTTON        2
`define IN_COUNT         3

`endif

// >>> verilog/door_position_led_indicator.v

`timescale 1ns/1ps
`default_nettype none
`include "door_lamp_map.vh"

module door_position_led_indicator #(
  parameter [31:0] POS_DEB_CYCLES   = `POS_DEB_CYC,
  parameter [31:0] PB_DEB_CYCLES    = `PB_DEB_CYC,
  parameter [31:0] LAMP_TEST_CYCLES = `LAMP_TEST_CYC,
  parameter [31:0] PULSE_CYCLES     = `CTRL_PULSE_CYC,
  parameter [31:0] ALT_CYCLES       = `ALT_TIME_CYC,
  parameter [31:0] FLASH_CYCLES     = `FLASH_HALF_CYC
) (
  input  wire REF_CLK,
  input  wire SYS_RST,
  input  wire CLK_EN,
  input  wire DOOR_SHUT_SENSE,
  input  wire DOOR_FULL_SENSE,
  input  wire PUSH_BUTTON_IN,
  output wire RED_LAMP_OUT,
  output wire GREEN_LAMP_OUT,
  output wire CONTROL_OUT
);

  // -----------------------------------------------------------------
  // state codes
  // -----------------------------------------------------------------
  localparam [2:0] ST_TEST_RED   = 3'h1;
  localparam [2:0] ST_TEST_GREEN = 3'h2;
  localparam [2:0] ST_RUN        = 3'h4;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // true on the last cycle of an interval of lim cycles
  function expired;
    input [31:0] cnt;
    input [31:0] lim;
    begin
      expired = ((cnt + 32'h1) >= lim);
    end
  endfunction

  // -----------------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------------
  wire [`IN_COUNT-1:0] raw_in;
  reg  [`IN_COUNT-1:0] sync1_q;
  reg  [`IN_COUNT-1:0] sync2_q;
  wire [`IN_COUNT-1:0] filt;

  assign raw_in = {PUSH_BUTTON_IN, DOOR_FULL_SENSE, DOOR_SHUT_SENSE};

  // pins are asynchronous; second stage is the only reader of the first
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      sync1_q <= 3'h7;
      sync2_q <= 3'h7;
    end else if (CLK_EN) begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  // -----------------------------------------------------------------
  // hold-time debouncers
  // -----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `IN_COUNT; gi = gi + 1) begin : g_deb
      localparam [31:0] LIM = (gi == `IN_BUTTON) ? PB_DEB_CYCLES : POS_DEB_CYCLES;
      reg        filt_q;
      reg [31:0] cnt_q;
      // any return to the filtered level restarts the hold count, so a
      // bouncing contact never accumulates toward a change
      always @(posedge REF_CLK) begin
        if (SYS_RST) begin
          filt_q <= 1'b1;                       // pullup level
          cnt_q  <= 32'h0;
        end else if (CLK_EN) begin
          if (sync2_q[gi] == filt_q) begin
            cnt_q <= 32'h0;
          end else if (expired(cnt_q, LIM)) begin
            filt_q <= sync2_q[gi];
            cnt_q  <= 32'h0;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
      end
      assign filt[gi] = filt_q;
    end
  endgenerate

  wire shut_f   = filt[`IN_SHUT];
  wire full_f   = filt[`IN_FULL];
  wire button_f = filt[`IN_BUTTON];

  // -----------------------------------------------------------------
  // control pulse
  // -----------------------------------------------------------------
  reg        button_prev_q;
  reg        pulse_q;
  reg [31:0] pulse_cnt_q;
  wire       press_edge;
  wire       press_active;

  // only the high-to-low edge of the filtered button fires; a held
  // button gives no further edges, which is the stuck-button guard
  assign press_edge   = button_prev_q & ~button_f;
  assign press_active = ~button_f | pulse_q;

  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      button_prev_q <= 1'b1;
      pulse_q       <= 1'b0;
      pulse_cnt_q   <= 32'h0;
    end else if (CLK_EN) begin
      button_prev_q <= button_f;
      if (pulse_q) begin
        // width is fixed by the counter alone, not by the button
        if (expired(pulse_cnt_q, PULSE_CYCLES)) begin
          pulse_q     <= 1'b0;
          pulse_cnt_q <= 32'h0;
        end else begin
          pulse_cnt_q <= pulse_cnt_q + 32'h1;
        end
      end else if (press_edge) begin
        pulse_q     <= 1'b1;
        pulse_cnt_q <= 32'h0;
      end
    end
  end

  // -----------------------------------------------------------------
  // alternating indication timers
  // -----------------------------------------------------------------
  wire       both_high;
  reg        both_prev_q;
  reg        alt_done_q;
  reg        flash_q;
  reg [31:0] alt_cnt_q;
  reg [31:0] flash_cnt_q;

  assign both_high = shut_f & full_f;

  // a fresh entry into the both-high case restarts the 30 s window
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      both_prev_q <= 1'b0;
      alt_done_q  <= 1'b0;
      flash_q     <= 1'b0;
      alt_cnt_q   <= 32'h0;
      flash_cnt_q <= 32'h0;
    end else if (CLK_EN) begin
      both_prev_q <= both_high;
      if (both_high & ~both_prev_q) begin
        alt_done_q  <= 1'b0;
        flash_q     <= 1'b0;
        alt_cnt_q   <= 32'h0;
        flash_cnt_q <= 32'h0;
      end else if (both_high & ~alt_done_q) begin
        if (expired(alt_cnt_q, ALT_CYCLES)) begin
          alt_done_q <= 1'b1;
        end
        alt_cnt_q <= alt_cnt_q + 32'h1;
        if (expired(flash_cnt_q, FLASH_CYCLES)) begin
          flash_q     <= ~flash_q;
          flash_cnt_q <= 32'h0;
        end else begin
          flash_cnt_q <= flash_cnt_q + 32'h1;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // position decode
  // -----------------------------------------------------------------
  reg pos_red_d;
  reg pos_green_d;

  // shut-low is tested first so the both-low case stays green only
  always @* begin
    pos_red_d   = 1'b0;
    pos_green_d = 1'b0;
    if (~shut_f) begin
      pos_green_d = 1'b1;
    end else if (~full_f) begin
      pos_red_d = 1'b1;
    end else if (alt_done_q) begin
      pos_red_d = 1'b1;
    end else begin
      pos_red_d   = ~flash_q;
      pos_green_d = flash_q;
    end
  end

  reg pos_red_q;
  reg pos_green_q;

  // held while a press is active so the lamp pair does not move
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      pos_red_q   <= 1'b0;
      pos_green_q <= 1'b0;
    end else if (CLK_EN) begin
      if (~press_active) begin
        pos_red_q   <= pos_red_d;
        pos_green_q <= pos_green_d;
      end
    end
  end

  // -----------------------------------------------------------------
  // lamp test sequencer
  // -----------------------------------------------------------------
  reg [2:0]  state_q;
  reg [2:0]  state_d;
  reg [31:0] test_cnt_q;
  wire       test_end;

  assign test_end = expired(test_cnt_q, LAMP_TEST_CYCLES);

  always @* begin
    case (state_q)
      ST_TEST_RED:   state_d = test_end ? ST_TEST_GREEN : ST_TEST_RED;
      ST_TEST_GREEN: state_d = test_end ? ST_RUN : ST_TEST_GREEN;
      ST_RUN:        state_d = ST_RUN;
      default:       state_d = ST_TEST_RED;
    endcase
  end

  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      state_q    <= ST_TEST_RED;
      test_cnt_q <= 32'h0;
    end else if (CLK_EN) begin
      state_q <= state_d;
      if (state_q == ST_RUN || test_end) begin
        test_cnt_q <= 32'h0;
      end else begin
        test_cnt_q <= test_cnt_q + 32'h1;
      end
    end
  end

  // -----------------------------------------------------------------
  // lamp outputs
  // -----------------------------------------------------------------
  reg red_q;
  reg green_q;
  reg red_d;
  reg green_d;

  // every branch drives at most one lamp, so the pair never both glow
  always @* begin
    case (state_q)
      ST_TEST_RED: begin
        red_d   = 1'b1;
        green_d = 1'b0;
      end
      ST_TEST_GREEN: begin
        red_d   = 1'b0;
        green_d = 1'b1;
      end
      ST_RUN: begin
        if (press_active) begin
          red_d   = 1'b1;
          green_d = 1'b0;
        end else begin
          red_d   = pos_red_q & ~pos_green_q;
          green_d = pos_green_q;
        end
      end
      default: begin
        red_d   = 1'b0;
        green_d = 1'b0;
      end
    endcase
  end

  // registered so the lamp pins never glitch between phases
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      red_q   <= 1'b0;
      green_q <= 1'b0;
    end else if (CLK_EN) begin
      red_q   <= red_d;
      green_q <= green_d;
    end
  end

  assign RED_LAMP_OUT   = red_q;
  assign GREEN_LAMP_OUT = green_q;
  assign CONTROL_OUT    = pulse_q;

endmodule // door_position_led_indicator

`default_nettype wire

// >>> tb/door_lamp_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module door_lamp_monitor #(
  parameter [31:0] PULSE_CYCLES     = 32'd20,
  parameter [31:0] LAMP_TEST_CYCLES = 32'd20
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic PUSH_BUTTON_IN,
  input wire logic RED_LAMP_OUT,
  input wire logic GREEN_LAMP_OUT,
  input wire logic CONTROL_OUT
);
  // ----
  // helper counters
  // ----
  logic [31:0] up_q;
  logic [31:0] wid_q;
  // a margin of three edges keeps run clear of the last lamp-test seam
  wire         run = up_q > 2 * LAMP_TEST_CYCLES + 3;

  // enabled edges since reset release, and width of the running pulse;
  // a frozen clock enable must not age either count
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      up_q  <= 32'h00000000;
      wid_q <= 32'h00000000;
    end else if (CLK_EN) begin
      up_q  <= (up_q == 32'hFFFFFFFF) ? up_q : up_q + 32'h00000001;
      wid_q <= CONTROL_OUT ? wid_q + 32'h00000001 : 32'h00000000;
    end
  end

  // ----
  // properties
  // ----
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_held_at_end;
    !PUSH_BUTTON_IN && $fell(CONTROL_OUT);
  endsequence
  sequence s_pulse_in_run;
    run && CONTROL_OUT;
  endsequence

  property p_one_lamp;
    !(RED_LAMP_OUT && GREEN_LAMP_OUT);
  endproperty
  a_one_lamp: assert property (p_one_lamp) else $error("both lamps lit");
  property p_width;
    $fell(CONTROL_OUT) |-> wid_q == PULSE_CYCLES;
  endproperty
  a_width: assert property (p_width) else $error("control pulse width wrong");
  property p_cause;
    $rose(CONTROL_OUT) |-> !$past(PUSH_BUTTON_IN, 4) && !$past(PUSH_BUTTON_IN, 6);
  endproperty
  a_cause: assert property (p_cause) else $error("pulse without steady press");
  property p_no_repeat;
    s_held_at_end |-> !CONTROL_OUT [*8];
  endproperty
  a_no_repeat: assert property (p_no_repeat) else $error("second pulse on held button");
  property p_test_red;
    up_q >= 2 && up_q < LAMP_TEST_CYCLES |-> RED_LAMP_OUT && !GREEN_LAMP_OUT;
  endproperty
  a_test_red: assert property (p_test_red) else $error("lamp test red phase wrong");
  property p_test_green;
    up_q >= LAMP_TEST_CYCLES + 2 && up_q < 2 * LAMP_TEST_CYCLES |-> GREEN_LAMP_OUT && !RED_LAMP_OUT;
  endproperty
  a_test_green: assert property (p_test_green) else $error("lamp test green phase wrong");
  property p_force;
    s_pulse_in_run |-> RED_LAMP_OUT && !GREEN_LAMP_OUT;
  endproperty
  a_force: assert property (p_force) else $error("press does not force red");
  property p_freeze;
    s_pulse_in_run ##1 CONTROL_OUT |-> $stable(RED_LAMP_OUT) && $stable(GREEN_LAMP_OUT);
  endproperty
  a_freeze: assert property (p_freeze) else $error("lamps moved during press");
endmodule // door_lamp_monitor
`default_nettype wire

// >>> tb/door_contact.sv
`timescale 1ns/1ps
`default_nettype none
module door_contact (
  input  wire logic clk,
  input  wire logic level,
  input  wire logic chatter,
  output var  logic pin
);
  // a real contact chatters before it settles; chatter never holds a level
  initial pin = 1'b1;
  always @(posedge clk) begin
    pin <= chatter ? ~pin : level;
  end
endmodule // door_contact
`default_nettype wire

// >>> tb/door_position_led_indicator_test.sv
`timescale 1ns/1ps
`default_nettype none
module door_position_led_indicator_test;
  // ----
  // setup
  // ----
  localparam [31:0] POS = 32'd20, PBD = 32'd5, LT = 32'd20, PUL = 32'd20;
  localparam [31:0] ALT = 32'd200, FL = 32'd10;
  logic       clk = 1'b0, rst = 1'b1, ctrl_d = 1'b0, en = 1'b1;
  logic       shut_l = 1'b0, full_l = 1'b1, btn_l = 1'b1, shut_ch = 1'b0, btn_ch = 1'b0;
  wire        shut_p, full_p, btn_p, red, green, ctrl;
  int         n_fail = 0, checked = 0, rises = 0, nr, ng;
  logic [3:0] rows [3] = '{4'b0101, 4'b1010, 4'b0001};

  always #5 clk = ~clk;
  door_contact shut_m (.clk(clk), .level(shut_l), .chatter(shut_ch), .pin(shut_p));
  door_contact full_m (.clk(clk), .level(full_l), .chatter(1'b0), .pin(full_p));
  door_contact btn_m (.clk(clk), .level(btn_l), .chatter(btn_ch), .pin(btn_p));
  door_position_led_indicator #(.POS_DEB_CYCLES(POS), .PB_DEB_CYCLES(PBD),
    .LAMP_TEST_CYCLES(LT), .PULSE_CYCLES(PUL), .ALT_CYCLES(ALT), .FLASH_CYCLES(FL)) DUT (
    .REF_CLK(clk), .SYS_RST(rst), .CLK_EN(en), .DOOR_SHUT_SENSE(shut_p),
    .DOOR_FULL_SENSE(full_p), .PUSH_BUTTON_IN(btn_p), .RED_LAMP_OUT(red),
    .GREEN_LAMP_OUT(green), .CONTROL_OUT(ctrl));

  // pulses as the relay would count them
  always @(posedge clk) begin
    ctrl_d <= ctrl;
    if (ctrl && !ctrl_d) rises <= rises + 1;
  end

  // ----
  // tasks
  // ----
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t saw %b want %b", $time, seen, exp);
    end
  endtask
  // sampled between edges so no edge update races the read
  task automatic count(input int n);
    nr = 0;
    ng = 0;
    repeat (n) begin
      @(negedge clk);
      if (red === 1'b1) nr++;
      if (green === 1'b1) ng++;
    end
  endtask
  task automatic results;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----
  // sequence
  // ----
  initial begin
    cyc(2);
    @(negedge clk);
    chk(red, 1'b0);
    chk(ctrl, 1'b0);
    cyc(1);
    rst <= 1'b0;
    cyc(LT / 2);
    @(negedge clk);
    chk(red & ~green, 1'b1);
    cyc(LT);
    @(negedge clk);
    chk(green & ~red, 1'b1);
    cyc(LT);
    for (int i = 0; i < 3; i++) begin
      shut_l <= rows[i][3];
      full_l <= rows[i][2];
      cyc(POS + 8);
      @(negedge clk);
      chk(red, rows[i][1]);
      chk(green, rows[i][0]);
      cyc(1);
    end
    // chatter never holds a level, so the filter must not follow it
    shut_l <= 1'b1;
    shut_ch <= 1'b1;
    cyc(2 * POS);
    shut_ch <= 1'b0;
    count(POS - 6);
    chk(ng == POS - 6, 1'b1);
    count(14);
    chk(red & ~green, 1'b1);
    cyc(1);
    full_l <= 1'b1;
    cyc(POS + 8);
    count(100);
    chk(nr + ng == 100 && ng >= 45 && ng <= 55, 1'b1);
    // still alternating just short of the end of the window
    count(ALT - 120);
    chk(ng == (ALT - 120) / 2, 1'b1);
    cyc(40);
    count(2 * FL);
    chk(nr == 2 * FL, 1'b1);
    cyc(1);
    shut_l <= 1'b0;
    cyc(POS + 8);
    shut_l <= 1'b1;
    cyc(POS + 8);
    count(4 * FL);
    chk(ng > 0, 1'b1);
    cyc(1);
    shut_l <= 1'b0;
    cyc(POS + 8);
    btn_l <= 1'b0;
    cyc(PBD - 2);
    btn_l <= 1'b1;
    cyc(PBD + 10);
    chk(rises == 0, 1'b1);
    btn_ch <= 1'b1;
    cyc(8);
    btn_ch <= 1'b0;
    btn_l <= 1'b0;
    cyc(PBD + 10);
    @(negedge clk);
    chk(ctrl, 1'b1);
    chk(red & ~green, 1'b1);
    // door moves during the press; the frozen green shows one cycle after release
    cyc(1);
    shut_l <= 1'b1;
    full_l <= 1'b0;
    cyc(3 * PUL);
    chk(rises == 1, 1'b1);
    btn_l <= 1'b1;
    count(PBD + 10);
    chk(ng == 1, 1'b1);
    chk(red & ~green, 1'b1);
    cyc(1);
    btn_l <= 1'b0;
    cyc(PBD + 6);
    btn_l <= 1'b1;
    cyc(2 * PUL);
    chk(rises == 2, 1'b1);
    // clock enable low must freeze the filters and the lamps
    en <= 1'b0;
    shut_l <= 1'b0;
    count(POS + 8);
    chk(nr == POS + 8, 1'b1);
    cyc(1);
    en <= 1'b1;
    cyc(POS + 8);
    @(negedge clk);
    chk(green & ~red, 1'b1);
    // a second reset in mid-run must rerun the lamp test
    cyc(1);
    rst <= 1'b1;
    cyc(2);
    @(negedge clk);
    chk(red | green, 1'b0);
    cyc(1);
    rst <= 1'b0;
    cyc(LT / 2);
    @(negedge clk);
    chk(red & ~green, 1'b1);
    cyc(2 * LT);
    results();
  end

  // the whole run needs about 890 cycles
  initial begin
    #40000;
    n_fail++;
    results();
  end
endmodule // door_position_led_indicator_test

bind door_position_led_indicator door_lamp_monitor #(.PULSE_CYCLES(PULSE_CYCLES),
  .LAMP_TEST_CYCLES(LAMP_TEST_CYCLES)) mon (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
  .CLK_EN(CLK_EN), .PUSH_BUTTON_IN(PUSH_BUTTON_IN), .RED_LAMP_OUT(RED_LAMP_OUT),
  .GREEN_LAMP_OUT(GREEN_LAMP_OUT), .CONTROL_OUT(CONTROL_OUT));
`default_nettype wire
